// ==== design/rx_message_indication.sv ====
// receive message indication sequencer towards client logic
`timescale 1ns/1ps
`include "rx_msg_defs.svh"

module rx_message_indication #(
   parameter bit msg_port_enable_param = 1'b1,
   parameter int DATA_W                = 8
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   in_valid,
   input  wire rx_msg_pkg::msg_type_t  in_type,
   input  wire rx_msg_pkg::msg_id_t    in_req_id,
   input  wire rx_msg_pkg::msg_id_t    in_vendor_id,
   input  wire rx_msg_pkg::msg_word_t  in_payload,
   input  wire logic                   in_has_data,
   output logic                        in_ready_q,
   output logic                        msg_valid_q,
   output rx_msg_pkg::msg_type_t       msg_type_q,
   output rx_msg_pkg::msg_byte_t       msg_data_q,
   output logic                        msg_reserved_q
);
   import rx_msg_pkg::*;

   // ===================================================
   // elaboration checks
   generate
      if (DATA_W != 8) begin : bad_width
         // the byte sequencing is fixed at eight bits per cycle
         $error("DATA_W must be 8");
      end
   endgenerate

   // ===================================================
   // declarations
   seq_state_t state_q;
   msg_id_t    req_id_q;
   msg_id_t    vendor_id_q;
   msg_word_t  payload_q;
   logic       vendor_q;
   msg_count_t len_q;
   msg_count_t idx_q;
   msg_count_t in_len;
   logic       in_vendor;
   msg_byte_t  next_byte;
   logic       accept;
   logic       last_beat;
   logic       start;

   // ===================================================
   // decode of the incoming message
   msg_len_lookup u_len (
      .msg_type  (in_type),
      .has_data  (in_has_data),
      .len       (in_len),
      .is_vendor (in_vendor)
   );

   msg_byte_select u_sel (
      .req_id    (req_id_q),
      .vendor_id (vendor_id_q),
      .payload   (payload_q),
      .is_vendor (vendor_q),
      .idx       (idx_q),
      .data      (next_byte)
   );

   // ===================================================
   // handshake terms
   // taking a message only from idle gives the gap for free: the cycle
   // after the last beat is always idle with valid low
   assign accept    = in_valid && in_ready_q;
   assign start     = accept && msg_port_enable_param &&
                      (in_len != `LEN_NONE);
   assign last_beat = (state_q == st_send) && (idx_q == len_q);

   // ===================================================
   // sequencer state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= st_idle;
      end else begin
         case (state_q)
            st_idle: begin
               if (start) begin
                  state_q <= st_send;
               end
            end
            st_send: begin
               if (last_beat) begin
                  state_q <= st_idle;
               end
            end
            default: begin
               state_q <= st_idle;
            end
         endcase
      end
   end

   // ===================================================
   // link side ready
   // ready falls as soon as a message is taken, so none is lost while the
   // client sees a pulse; with the port disabled messages are drained
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_ready_q <= 1'b0;
      end else if (!msg_port_enable_param) begin
         in_ready_q <= 1'b1;
      end else if (start) begin
         in_ready_q <= 1'b0;
      end else if (state_q == st_idle || last_beat) begin
         in_ready_q <= !last_beat;
      end
   end

   // ===================================================
   // captured message fields
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_id_q    <= '0;
         vendor_id_q <= '0;
         payload_q   <= '0;
         vendor_q    <= 1'b0;
         len_q       <= `LEN_NONE;
      end else if (start) begin
         req_id_q    <= in_req_id;
         vendor_id_q <= in_vendor_id;
         payload_q   <= in_payload;
         vendor_q    <= in_vendor;
         len_q       <= in_len;
      end
   end

   // ===================================================
   // byte position counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_q <= `RST_IDX;
      end else if (start) begin
         idx_q <= `IDX_FIRST;
      end else if (state_q == st_send && !last_beat) begin
         idx_q <= idx_q + `IDX_FIRST;
      end
   end

   // ===================================================
   // client side outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msg_valid_q <= 1'b0;
      end else if (start) begin
         msg_valid_q <= 1'b1;
      end else if (last_beat) begin
         msg_valid_q <= 1'b0;
      end
   end

   // type is loaded only at the start, so it holds through the pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msg_type_q <= `RST_TYPE;
      end else if (start) begin
         msg_type_q <= in_type;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msg_data_q <= `RST_BYTE;
      end else if (start) begin
         msg_data_q <= in_req_id[`RID_BUS_MSB:`RID_BUS_LSB];
      end else if (state_q == st_send && !last_beat) begin
         msg_data_q <= next_byte;
      end
   end

   // reserved codes are swallowed; one-cycle pulse for observation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         msg_reserved_q <= 1'b0;
      end else begin
         msg_reserved_q <= accept && msg_port_enable_param &&
                           (in_len == `LEN_NONE);
      end
   end

endmodule

// ==== design/rx_msg_defs.svh ====
// constants for the receive message indication block
`ifndef RX_MSG_DEFS_SVH
`define RX_MSG_DEFS_SVH

// ===================================================
// message type codes on the indication type bus
`define MT_ERR_COR        5'h00
`define MT_ERR_FATAL      5'h02
`define MT_INTX_FIRST     5'h03
`define MT_INTX_LAST      5'h0A
`define MT_PM_PME         5'h0B
`define MT_PME_TURN_OFF   5'h0D
`define MT_PM_NAK         5'h0E
`define MT_SLOT_POWER     5'h0F
`define MT_LTR            5'h10
`define MT_OBFF           5'h11
`define MT_UNLOCK         5'h12
`define MT_VENDOR_T0      5'h13
`define MT_VENDOR_T1      5'h14
`define MT_ATS_FIRST      5'h15
`define MT_ATS_LAST       5'h18

// ===================================================
// indication lengths in cycles
`define LEN_SHORT         4'h2
`define LEN_OBFF          4'h3
`define LEN_VENDOR_NODATA 4'h4
`define LEN_SIX           4'h6
`define LEN_VENDOR_DATA   4'h8
`define LEN_NONE          4'h0

// ===================================================
// byte positions inside one indication
`define IDX_FIRST         4'h1
`define IDX_VID_LO        4'h2
`define IDX_VID_HI        4'h3
`define IDX_VENDOR_PL     4'h4
`define IDX_PL            4'h2

// ===================================================
// field positions
`define RID_BUS_MSB       15
`define RID_BUS_LSB       8
`define RID_DEVFN_MSB     7
`define RID_DEVFN_LSB     0
`define VID_LO_MSB        7
`define VID_LO_LSB        0
`define VID_HI_MSB        15
`define VID_HI_LSB        8

// ===================================================
// reset values
`define RST_TYPE          5'h00
`define RST_BYTE          8'h00
`define RST_IDX           4'h0

`endif

// ==== design/rx_msg_pkg.sv ====
// types shared by the receive message indication block
package rx_msg_pkg;

   // ===================================================
   // basic field types
   typedef logic [4:0]  msg_type_t;
   typedef logic [7:0]  msg_byte_t;
   typedef logic [15:0] msg_id_t;
   typedef logic [31:0] msg_word_t;
   typedef logic [3:0]  msg_count_t;

   // ===================================================
   // sequencer states
   typedef enum logic {
      st_idle,
      st_send
   } seq_state_t;

endpackage

// ==== design/msg_len_lookup.sv ====
// maps a message type to its indication length in cycles
`timescale 1ns/1ps
`include "rx_msg_defs.svh"

module msg_len_lookup (
   input  wire rx_msg_pkg::msg_type_t  msg_type,
   input  wire logic                   has_data,
   output rx_msg_pkg::msg_count_t      len,
   output logic                        is_vendor
);
   import rx_msg_pkg::*;

   // ===================================================
   // length decode
   always_comb begin
      is_vendor = 1'b0;
      if (msg_type <= `MT_INTX_LAST) begin
         len = `LEN_SHORT;
      end else if (msg_type <= `MT_PM_NAK) begin
         len = `LEN_SHORT;
      end else if (msg_type == `MT_SLOT_POWER) begin
         len = `LEN_SIX;
      end else if (msg_type == `MT_LTR) begin
         len = `LEN_SIX;
      end else if (msg_type == `MT_OBFF) begin
         len = `LEN_OBFF;
      end else if (msg_type == `MT_UNLOCK) begin
         len = `LEN_SHORT;
      end else if (msg_type <= `MT_VENDOR_T1) begin
         is_vendor = 1'b1;
         // only the first payload word fits this port
         len = has_data ? `LEN_VENDOR_DATA
                        : `LEN_VENDOR_NODATA;
      end else if (msg_type <= `MT_ATS_LAST) begin
         len = `LEN_SHORT;
      end else begin
         len = `LEN_NONE;
      end
   end

endmodule

// ==== design/msg_byte_select.sv ====
// picks the parameter byte for a given position of an indication
`timescale 1ns/1ps
`include "rx_msg_defs.svh"

module msg_byte_select (
   input  wire rx_msg_pkg::msg_id_t    req_id,
   input  wire rx_msg_pkg::msg_id_t    vendor_id,
   input  wire rx_msg_pkg::msg_word_t  payload,
   input  wire logic                   is_vendor,
   input  wire rx_msg_pkg::msg_count_t idx,
   output rx_msg_pkg::msg_byte_t       data
);
   import rx_msg_pkg::*;

   function automatic msg_byte_t word_byte(input msg_word_t w,
                                           input msg_count_t n);
      msg_byte_t b;
      b = w[8*n[1:0] +: 8];
      return b;
   endfunction

   // ===================================================
   // position decode
   always_comb begin
      if (idx == `IDX_FIRST) begin
         data = req_id[`RID_DEVFN_MSB:`RID_DEVFN_LSB];
      end else if (is_vendor && idx == `IDX_VID_LO) begin
         data = vendor_id[`VID_LO_MSB:`VID_LO_LSB];
      end else if (is_vendor && idx == `IDX_VID_HI) begin
         data = vendor_id[`VID_HI_MSB:`VID_HI_LSB];
      end else if (is_vendor) begin
         data = word_byte(payload, idx - `IDX_VENDOR_PL);
      end else begin
         // ltr: snoop in low half, no-snoop in high half
         data = word_byte(payload, idx - `IDX_PL);
      end
   end

endmodule

// ==== testbench/rx_msg_monitor.sv ====
// assertions on the receive message indication ports
`timescale 1ns/1ps

module rx_msg_monitor #(
   parameter bit msg_port_enable_param = 1'b1,
   parameter int DATA_W                = 8
) (
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic                   in_valid,
   input wire rx_msg_pkg::msg_type_t  in_type,
   input wire rx_msg_pkg::msg_id_t    in_req_id,
   input wire rx_msg_pkg::msg_id_t    in_vendor_id,
   input wire rx_msg_pkg::msg_word_t  in_payload,
   input wire logic                   in_has_data,
   input wire logic                   in_ready_q,
   input wire logic                   msg_valid_q,
   input wire rx_msg_pkg::msg_type_t  msg_type_q,
   input wire rx_msg_pkg::msg_byte_t  msg_data_q,
   input wire logic                   msg_reserved_q
);
   import rx_msg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic tk;
   logic vnd;
   logic shrt;
   // ========================================================
   // take decode
   assign tk = in_valid && in_ready_q && msg_port_enable_param;
   assign vnd = in_type == 5'h13 || in_type == 5'h14;
   assign shrt = in_type < 5'h0F || in_type == 5'h12
                 || (in_type > 5'h14 && in_type < 5'h19);
   // ========================================================
   // assertions
   a_type_steady: assert property (msg_valid_q && $past(msg_valid_q)
      |-> $stable(msg_type_q)) else $error("type moved in pulse");
   a_pulse_start: assert property (tk && in_type < 5'h19 |=> msg_valid_q
      && msg_type_q == $past(in_type) && msg_data_q == $past(in_req_id[15:8]))
      else $error("bad pulse start");
   a_short_len: assert property (tk && shrt |=> msg_valid_q[*2]
      ##1 !msg_valid_q) else $error("short length wrong");
   a_six_len: assert property (tk && (in_type == 5'h0F || in_type == 5'h10)
      |=> msg_valid_q[*6] ##1 !msg_valid_q) else $error("six wrong");
   a_flush_len: assert property (tk && in_type == 5'h11 |=> msg_valid_q[*3]
      ##1 !msg_valid_q) else $error("flush length wrong");
   a_vendor_full: assert property (tk && vnd && in_has_data |=>
      msg_valid_q[*8] ##1 !msg_valid_q) else $error("vendor 8 wrong");
   a_vendor_bare: assert property (tk && vnd && !in_has_data |=>
      msg_valid_q[*4] ##1 !msg_valid_q) else $error("vendor 4 wrong");
   a_vendor_word: assert property (tk && vnd && in_has_data |=> ##4
      msg_data_q == $past(in_payload[7:0], 5)) else $error("vendor pl");
   a_power_byte: assert property (tk && in_type == 5'h0F |=> ##2
      msg_data_q == $past(in_payload[7:0], 3)) else $error("power pl");
   a_reserved_drop: assert property (tk && in_type > 5'h18 |=> msg_reserved_q
      && !msg_valid_q) else $error("reserved not dropped");
   a_busy_gap: assert property (msg_valid_q |-> !in_ready_q)
      else $error("ready during pulse");
   // ========================================================
   // covers
   c_power: cover property (tk && in_type == 5'h0F);
   c_reserved: cover property (tk && in_type > 5'h18);
   // ready returns two cycles after the last beat, so the tightest gap is two
   c_back2back: cover property ($fell(msg_valid_q) ##2 msg_valid_q);
endmodule

bind rx_message_indication rx_msg_monitor #(
   .msg_port_enable_param(msg_port_enable_param), .DATA_W(DATA_W)) mon (
   .clk(clk), .reset_n(reset_n), .in_valid(in_valid), .in_type(in_type),
   .in_req_id(in_req_id), .in_vendor_id(in_vendor_id),
   .in_payload(in_payload), .in_has_data(in_has_data),
   .in_ready_q(in_ready_q), .msg_valid_q(msg_valid_q),
   .msg_type_q(msg_type_q), .msg_data_q(msg_data_q),
   .msg_reserved_q(msg_reserved_q));

// ==== testbench/msg_client_model.sv ====
// client logic model that captures every indication byte
`timescale 1ns/1ps

module msg_client_model (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  msg_valid_q,
   input  wire rx_msg_pkg::msg_type_t msg_type_q,
   input  wire rx_msg_pkg::msg_byte_t msg_data_q,
   output rx_msg_pkg::msg_type_t      got_type_q,
   output rx_msg_pkg::msg_count_t     got_cnt_q,
   output logic [63:0]                got_bytes_q
);
   import rx_msg_pkg::*;
   logic       prev_q;
   msg_count_t idx;
   // ========================================================
   // capture: no stall exists, so every valid cycle is taken
   assign idx = prev_q ? got_cnt_q : 4'h0;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q      <= 1'b0;
         got_cnt_q   <= 4'h0;
         got_type_q  <= 5'h00;
         got_bytes_q <= 64'h0;
      end else begin
         prev_q <= msg_valid_q;
         if (msg_valid_q) begin
            got_bytes_q[idx*8 +: 8] <= msg_data_q;
            got_cnt_q               <= idx + 4'h1;
            got_type_q              <= msg_type_q;
         end
      end
   end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the receive message indication block
`timescale 1ns/1ps

module tb;
   import rx_msg_pkg::*;
   logic       clk, reset_n, in_valid, in_has_data;
   logic       in_ready_q, msg_valid_q, msg_reserved_q;
   msg_type_t  in_type, msg_type_q, got_type_q;
   msg_id_t    in_req_id, in_vendor_id;
   msg_word_t  in_payload;
   msg_byte_t  msg_data_q;
   msg_count_t got_cnt_q;
   logic [63:0] got_bytes_q;
   int         n_fail, total_checks, cyc;
   logic       off_ready_q, off_valid_q, off_resv_q;
   msg_type_t  off_type_q;
   msg_byte_t  off_data_q;
   int         n_off;
   // ========================================================
   // design and client model
   rx_message_indication uut (.clk(clk), .reset_n(reset_n),
      .in_valid(in_valid), .in_type(in_type), .in_req_id(in_req_id),
      .in_vendor_id(in_vendor_id), .in_payload(in_payload),
      .in_has_data(in_has_data), .in_ready_q(in_ready_q),
      .msg_valid_q(msg_valid_q), .msg_type_q(msg_type_q),
      .msg_data_q(msg_data_q), .msg_reserved_q(msg_reserved_q));
   msg_client_model client (.clk(clk), .reset_n(reset_n),
      .msg_valid_q(msg_valid_q), .msg_type_q(msg_type_q),
      .msg_data_q(msg_data_q), .got_type_q(got_type_q),
      .got_cnt_q(got_cnt_q), .got_bytes_q(got_bytes_q));
   // second copy with the port disabled: it must drain and stay silent
   rx_message_indication #(.msg_port_enable_param(1'b0)) uut_off (
      .clk(clk), .reset_n(reset_n), .in_valid(in_valid),
      .in_type(in_type), .in_req_id(in_req_id),
      .in_vendor_id(in_vendor_id), .in_payload(in_payload),
      .in_has_data(in_has_data), .in_ready_q(off_ready_q),
      .msg_valid_q(off_valid_q), .msg_type_q(off_type_q),
      .msg_data_q(off_data_q), .msg_reserved_q(off_resv_q));
   always @(posedge clk)
      if (reset_n === 1'b1 && (off_valid_q !== 1'b0 ||
                               off_resv_q !== 1'b0)) n_off++;
   // ========================================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         test_done();
      end
   end
   // ========================================================
   // helpers
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // link offer held until the edge where ready is seen high
   // offers never run ahead of ready, so nothing can overflow
   task automatic offer(msg_type_t t, msg_id_t id, msg_id_t vid,
                        msg_word_t pl, logic hd);
      int i;
      @(negedge clk);
      in_valid = 1'b1; in_type = t; in_req_id = id;
      in_vendor_id = vid; in_payload = pl; in_has_data = hd;
      for (i = 0; i < 30 && in_ready_q !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      in_valid = 1'b0;
   endtask
   task automatic go(msg_type_t t, msg_id_t id, msg_id_t vid,
                     msg_word_t pl, logic hd, msg_count_t len);
      int i;
      logic [63:0] e, m;
      offer(t, id, vid, pl, hd);
      for (i = 0; i < 30 && msg_valid_q !== 1'b1; i++) @(negedge clk);
      for (i = 0; i < 30 && msg_valid_q === 1'b1; i++) @(negedge clk);
      if (t == 5'h13 || t == 5'h14) e = {pl, vid, id[7:0], id[15:8]};
      else e = {16'h0, pl, id[7:0], id[15:8]};
      m = (64'h1 << (len * 8)) - 64'h1;
      chk({got_type_q, got_cnt_q}, {t, len});
      chk(got_bytes_q & m, e & m);
   endtask
   // ========================================================
   // scenarios
   task automatic t_short();
      for (int t = 0; t < 25; t++)
         if (t < 15 || t == 18 || t > 20)
            go(5'(t), 16'hA500 | 16'(t), 16'h0, 32'h0, 1'b0, 4'h2);
   endtask
   task automatic t_six();
      go(5'h0F, 16'h3C5A, 16'h0, 32'h89AB_CDEF, 1'b0, 4'h6);
      go(5'h10, 16'h1E2D, 16'h0, 32'h1234_5678, 1'b0, 4'h6);
   endtask
   task automatic t_flush();
      go(5'h11, 16'h4B69, 16'h0, 32'hFFFF_FFA7, 1'b0, 4'h3);
   endtask
   task automatic t_vendor();
      go(5'h13, 16'h0102, 16'hBEEF, 32'hCAFE_F00D, 1'b0, 4'h4);
      go(5'h14, 16'h0304, 16'h5AA5, 32'h0BAD_1DEA, 1'b1, 4'h8);
      go(5'h13, 16'h0506, 16'hC3D2, 32'h7654_3210, 1'b1, 4'h8);
      go(5'h14, 16'h0708, 16'h1357, 32'h9999_8888, 1'b0, 4'h4);
   endtask
   task automatic t_reserved();
      for (int t = 25; t < 32; t++) begin
         offer(5'(t), 16'hFFFF, 16'h0, 32'h0, 1'b0);
         chk({in_ready_q, msg_reserved_q, msg_valid_q}, 64'h6);
      end
   endtask
   task automatic t_disabled();
      chk(64'(n_off), 64'h0);
      chk({off_ready_q, off_type_q, off_data_q}, 64'h2000);
   endtask
   task automatic t_back2back();
      offer(5'h0F, 16'h2468, 16'h0, 32'h1111_2222, 1'b0);
      go(5'h11, 16'h1357, 16'h0, 32'h0000_005C, 1'b0, 4'h3);
   endtask
   // ========================================================
   // main sequence
   initial begin
      n_fail = 0; total_checks = 0; cyc = 0; n_off = 0;
      reset_n = 1'b0; in_valid = 1'b0; in_type = 5'h00;
      in_req_id = 16'h0; in_vendor_id = 16'h0;
      in_payload = 32'h0; in_has_data = 1'b0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      t_short();
      t_six();
      t_flush();
      t_vendor();
      t_reserved();
      t_back2back();
      t_disabled();
      test_done();
   end
endmodule
